// file: core/usr_core.sv
`timescale 1ns/1ps
// Operation
// - Eight-bit word held in flip-flops; only hold, shift right, shift left, load.
// - Mode selects pick the operation: 00 hold, lo-only right, hi-only left, both load.
// - Besides clear, the word changes only on a rising edge of clk_in.
// - Low clear input empties all stages at once, whatever clock or mode.
// - Clear is asynchronous, active low, on its own pin.
// - Shift right takes the right serial input into stage zero, stages move up.
// - Shift left takes the left serial input into stage seven, stages move down.
// - Each stage drives its own shared pin; load samples those same pins.
// - Stage zero and stage seven always appear on their own serial outputs.
// - Either output enable high releases every shared pin.
// - With pins released, shifting, holding, loading and clear go on as usual.
// - Both mode selects high also release the shared pins.

module usr_core
  import usr_pkg::*;
#(
  parameter int unsigned WIDTH = usr_pkg::WORD_W
) (
  // Bus clock and reset.
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  // AHB-Lite slave.
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic [31:0]                  hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  // Register pins.
  input  wire logic                    async_clear_n,
  input  wire usr_pkg::usr_ctl_t       ctl_pins,
  input  wire logic [WIDTH-1:0]        shared_par_pins_in,
  output usr_pkg::usr_pins_drv_t       shared_par_pins_drv,
  // Serial outputs for cascading.
  output logic                         ser_out_stage_first,
  output logic                         ser_out_stage_last
);
  import usr_pkg::*;

  initial begin
    if (WIDTH != WORD_W) begin
      $error("usr_core: WIDTH must equal the package word width");
    end
    if (WIDTH < 2) begin
      $error("usr_core: WIDTH must be at least two for shifting");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next word for a given mode.

  function automatic logic [WORD_W-1:0] next_word(
    input usr_mode_t         mode,
    input logic [WORD_W-1:0] cur,
    input logic [WORD_W-1:0] pins,
    input logic              ser_r,
    input logic              ser_l
  );
    logic [WORD_W-1:0] res;
    res = cur;
    unique case (mode)
      USR_HOLD: res = cur;
      USR_SHR:  res = {cur[WORD_W-2:0], ser_r};
      USR_SHL:  res = {ser_l, cur[WORD_W-1:1]};
      USR_LOAD: res = pins;
    endcase
    return res;
  endfunction : next_word

  ////////////////////////////////////////////////////////////////////////////
  // Clear handling. Assertion is immediate, release is synchronised so the
  // stages never leave clear close to a clock edge.

  logic       clear_src_n;
  logic [1:0] clear_sync_r;
  logic       stage_rst_n;

  assign clear_src_n = hresetn & async_clear_n;

  always_ff @(posedge hclk or negedge clear_src_n) begin
    if (!clear_src_n) begin
      clear_sync_r <= 2'h0;
    end else begin
      clear_sync_r <= {clear_sync_r[0], 1'b1};
    end
  end

  assign stage_rst_n = clear_sync_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers. Control and data pass the same two stages so that
  // the data seen at a detected clk_in edge are the data of that edge.

  localparam int unsigned CTL_W = $bits(usr_ctl_t);

  logic [CTL_W-1:0]  ctl_s1_r;
  logic [CTL_W-1:0]  ctl_s2_r;
  logic [WIDTH-1:0]  pin_s1_r;
  logic [WIDTH-1:0]  pin_s2_r;
  logic              clk_prev_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_s1_r <= '0;
      ctl_s2_r <= '0;
    end else begin
      ctl_s1_r <= ctl_pins;
      ctl_s2_r <= ctl_s1_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= shared_par_pins_in;
      pin_s2_r <= pin_s1_r;
    end
  end

  // The edge flop reads the second stage only, so a metastable first stage
  // can never reach the edge detector. It resets low, the idle level of
  // clk_in, so leaving reset does not look like an edge.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_prev_r <= 1'b0;
    end else begin
      clk_prev_r <= ctl_s2_r[CTL_W-1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded pin state.

  usr_ctl_t  ctl_sync;
  usr_mode_t mode_sync;
  logic      clk_rise;
  logic      step_en_r;
  logic      step;
  logic      drive_nxt;

  assign ctl_sync  = usr_ctl_t'(ctl_s2_r);
  assign mode_sync = usr_mode_t'({ctl_sync.mode_sel_hi, ctl_sync.mode_sel_lo});
  assign clk_rise  = ctl_sync.clk_in & ~clk_prev_r;
  // A paused register drops edges rather than queueing them, so resuming
  // never replays an old step.
  assign step      = clk_rise & step_en_r;

  // Drivers are on only with both enables low and no load selected.
  assign drive_nxt = ~ctl_sync.bus_drive_en1_n & ~ctl_sync.bus_drive_en2_n
                   & (mode_sync != USR_LOAD);

  ////////////////////////////////////////////////////////////////////////////
  // Storage stages. The pin drivers do not gate them, so released pins
  // leave every operation running.

  logic [WIDTH-1:0] word_r;
  logic [WIDTH-1:0] word_nxt;
  usr_mode_t        last_mode_r;

  assign word_nxt = step ? next_word(mode_sync, word_r, pin_s2_r,
                                     ctl_sync.ser_in_right_shift,
                                     ctl_sync.ser_in_left_shift)
                         : word_r;

  always_ff @(posedge hclk or negedge stage_rst_n) begin
    if (!stage_rst_n) begin
      word_r <= WORD_RST;
    end else begin
      word_r <= word_nxt;
    end
  end

  // The last applied mode is kept for software; it follows honoured edges
  // only, so a mode change without a clk_in edge is not reported.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_mode_r <= USR_HOLD;
    end else if (step) begin
      last_mode_r <= mode_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers. Enables are registered so every output leaves a flop.

  logic [WIDTH-1:0] oe_n_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oe_n_r <= OE_N_RST;
    end else begin
      oe_n_r <= {WIDTH{~drive_nxt}};
    end
  end

  assign shared_par_pins_drv.out  = word_r;
  assign shared_par_pins_drv.oe_n = oe_n_r;
  assign ser_out_stage_first      = word_r[0];
  assign ser_out_stage_last       = word_r[WIDTH-1];

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave. Zero wait states: reads are decoded in the address
  // phase and registered into the data phase; writes land at the end of
  // the data phase.

  logic        addr_ok;
  logic        wr_req;
  logic        rd_req;
  logic        is_ctrl;
  logic        is_stat;
  logic        wr_pend_r;
  logic [31:0] wr_addr_r;
  logic [31:0] rd_val;
  logic [31:0] hrdata_r;

  assign addr_ok = hsel & hready & (htrans == HTRANS_NONSEQ) & (hsize == HSIZE_WORD);
  assign wr_req  = addr_ok & hwrite;
  assign rd_req  = addr_ok & ~hwrite;
  assign is_ctrl = (haddr == CTRL_ADDR);
  assign is_stat = (haddr == STATUS_ADDR);

  // Status fields. All eight pin enables switch together, so one of them
  // stands for the whole group.
  logic             stat_drive;
  logic [1:0]       stat_mode;
  logic [WIDTH-1:0] stat_word;
  logic [31:0]      ctrl_val;
  logic [31:0]      stat_val;
  logic             wr_ctrl;

  assign stat_drive = ~oe_n_r[0];
  assign stat_mode  = last_mode_r;
  assign stat_word  = word_r;
  assign ctrl_val   = {31'h0, step_en_r};
  assign stat_val   = {21'h0, stat_drive, stat_mode, stat_word};

  // Unmapped addresses read as zero and ignore writes.
  assign rd_val = is_ctrl ? ctrl_val
                : is_stat ? stat_val
                : 32'h0;

  // Write data only arrive in the data phase, so the request is kept
  // until that phase closes.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
    end else begin
      wr_pend_r <= wr_req;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_addr_r <= 32'h0;
    end else if (wr_req) begin
      wr_addr_r <= haddr;
    end
  end

  // Read data stand for the data phase only and fall back to zero, so a
  // stale word never looks like a fresh answer.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0;
    end else begin
      hrdata_r <= rd_req ? rd_val : 32'h0;
    end
  end

  assign wr_ctrl = wr_pend_r & (wr_addr_r == CTRL_ADDR);

  // Software may pause the register by ignoring clk_in edges.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      step_en_r <= CTRL_RST[CTRL_STEP_EN_BIT];
    end else if (wr_ctrl) begin
      step_en_r <= hwdata[CTRL_STEP_EN_BIT];
    end
  end

  assign hrdata    = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;

endmodule : usr_core

// file: core/usr_pkg.sv
package usr_pkg;

  // Width of the stored word and of the shared pin group.
  localparam int unsigned WORD_W = 8;

  // Register byte addresses on the bus.
  localparam logic [31:0] CTRL_ADDR   = 32'h0000_0000;
  localparam logic [31:0] STATUS_ADDR = 32'h0000_0004;

  // Control register layout and value after reset.
  localparam int unsigned CTRL_STEP_EN_BIT = 0;
  localparam logic [31:0] CTRL_RST         = 32'h0000_0001;

  // Status register layout.
  localparam int unsigned STAT_WORD_LSB  = 0;
  localparam int unsigned STAT_MODE_LSB  = 8;
  localparam int unsigned STAT_DRIVE_BIT = 10;

  // Depth of the synchronisers on pin inputs.
  localparam int unsigned SYNC_STAGES = 2;

  // Reset values of the storage and the pin drivers.
  localparam logic [WORD_W-1:0] WORD_RST   = 8'h00;
  localparam logic [WORD_W-1:0] OE_N_RST   = 8'hff;

  // AHB-Lite encodings used by the slave.
  localparam logic [1:0] HTRANS_IDLE   = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  // Operating modes, packed as {mode_sel_hi, mode_sel_lo}.
  typedef enum logic [1:0] {
    USR_HOLD  = 2'h0,
    USR_SHR   = 2'h1,
    USR_SHL   = 2'h2,
    USR_LOAD  = 2'h3
  } usr_mode_t;

  // Control pins of the register, as they arrive from outside.
  typedef struct packed {
    logic clk_in;
    logic mode_sel_hi;
    logic mode_sel_lo;
    logic ser_in_right_shift;
    logic ser_in_left_shift;
    logic bus_drive_en1_n;
    logic bus_drive_en2_n;
  } usr_ctl_t;

  // Shared parallel pin group: the driven word and its per-pin enables.
  typedef struct packed {
    logic [WORD_W-1:0] out;
    logic [WORD_W-1:0] oe_n;
  } usr_pins_drv_t;

endpackage : usr_pkg

// file: tb/usr_bus_host.sv
`timescale 1ns/1ps
module usr_bus_host (
  // Clock.
  input  wire logic                   hclk,
  // Host side.
  input  wire logic                   drive_en,
  input  wire logic [7:0]             drive_val,
  // Pin group.
  input  wire usr_pkg::usr_pins_drv_t pins_drv,
  output logic [7:0]                  pins_lvl
);
  import usr_pkg::*;
  logic [7:0] last_r = 8'h00;
  // The host waits until every driver has let go, so a load never fights the register.
  wire        host_on = drive_en && &pins_drv.oe_n;
  // Undriven lines have no pull, so they toggle instead of keeping a stale level.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pins_lvl[i] = !pins_drv.oe_n[i] ? pins_drv.out[i] : host_on ? drive_val[i] : !last_r[i];
    end
  end
  always_ff @(posedge hclk) begin
    last_r <= pins_lvl;
  end
endmodule : usr_bus_host

// file: tb/usr_core_checker.sv
`timescale 1ns/1ps
module usr_core_checker (
  // Clock and reset.
  input wire logic                   hclk,
  input wire logic                   hresetn,
  // Watched ports.
  input wire logic                   hreadyout,
  input wire logic                   hresp,
  input wire logic                   async_clear_n,
  input wire usr_pkg::usr_ctl_t      ctl_pins,
  input wire logic [7:0]             shared_par_pins_in,
  input wire usr_pkg::usr_pins_drv_t shared_par_pins_drv,
  input wire logic                   ser_out_stage_first,
  input wire logic                   ser_out_stage_last
);
  import usr_pkg::*;
  wire [7:0] w  = shared_par_pins_drv.out;
  wire [1:0] md = {ctl_pins.mode_sel_hi, ctl_pins.mode_sel_lo};
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////////////
  clear_word_a: assert property (!async_clear_n |-> w == 8'h00 && !ser_out_stage_last)
    else $error("word not cleared");
  ser_mirror_a: assert property (ser_out_stage_first == w[0] && ser_out_stage_last == w[7])
    else $error("serial outputs differ from word");
  bus_okay_a: assert property (hreadyout && hresp == HRESP_OKAY)
    else $error("bus answer not okay");
  en_release_a: assert property ((ctl_pins.bus_drive_en1_n || ctl_pins.bus_drive_en2_n)[*4] |->
    shared_par_pins_drv.oe_n == 8'hff) else $error("pins driven while disabled");
  load_release_a: assert property ((md == 2'h3)[*4] |-> shared_par_pins_drv.oe_n == 8'hff)
    else $error("pins driven in load mode");
  pin_drive_a: assert property ((!ctl_pins.bus_drive_en1_n && !ctl_pins.bus_drive_en2_n && md != 2'h3)[*4]
    |-> shared_par_pins_drv.oe_n == 8'h00) else $error("pins not driven");
  // A clear may land at any moment, so only edge-free, clear-free stretches must keep the word.
  edge_only_a: assert property ((async_clear_n && !$rose(ctl_pins.clk_in))[*5] |=> $stable(w) || !async_clear_n)
    else $error("word changed without an edge");
  // The word moves at the second edge after clk_in is first seen high, so it is compared one edge later.
  shift_right_a: assert property ($rose(ctl_pins.clk_in) && md == 2'h1 ##0 async_clear_n[*3] |=>
    w[7:1] == $past(w[6:0]) && w[0] == $past(ctl_pins.ser_in_right_shift, 3)) else $error("bad shift right");
  shift_left_a: assert property ($rose(ctl_pins.clk_in) && md == 2'h2 ##0 async_clear_n[*3] |=>
    w[6:0] == $past(w[7:1]) && w[7] == $past(ctl_pins.ser_in_left_shift, 3)) else $error("bad shift left");
  par_load_a: assert property ($rose(ctl_pins.clk_in) && md == 2'h3 ##0 async_clear_n[*4] |=>
    w == $past(shared_par_pins_in, 4)) else $error("bad parallel load");
endmodule : usr_core_checker

// file: tb/usr_core_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin error_cnt++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module usr_core_tb;
  import usr_pkg::*;
  logic          hclk, hresetn, hsel, hwrite, hreadyout, hresp, async_clear_n, sfirst, slast, drv_en, rd_ph;
  logic [31:0]   haddr, hwdata, hrdata, r;
  logic [1:0]    htrans;
  logic [2:0]    hsize;
  logic [7:0]    pins, drv_val, exp_w;
  logic [63:0]   q[$];
  logic [63:0]   n;
  usr_ctl_t      ctl;
  usr_pins_drv_t pdrv;
  int            error_cnt, checked;
  usr_core usr_core_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .async_clear_n(async_clear_n), .ctl_pins(ctl), .shared_par_pins_in(pins),
    .shared_par_pins_drv(pdrv), .ser_out_stage_first(sfirst), .ser_out_stage_last(slast));
  usr_bus_host usr_bus_host_i (.hclk(hclk), .drive_en(drv_en), .drive_val(drv_val), .pins_drv(pdrv), .pins_lvl(pins));
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  task automatic wait_rdy();
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && k < 64) begin
      k++;
      @(posedge hclk);
    end
    if (k >= 64) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask : wait_rdy
  // Reads note the expected word, masked to the bits that are predictable.
  task automatic ahb(input logic w, input logic [31:0] a, d, m);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= a;
    wait_rdy();
    htrans <= HTRANS_IDLE;
    hwdata <= d;
    if (!w) q.push_back({m, d & m});
    wait_rdy();
  endtask : ahb
  task automatic pin_step(input logic [1:0] md, input logic sr, sl, e1, e2, input logic [7:0] pv);
    {ctl.mode_sel_hi, ctl.mode_sel_lo, ctl.ser_in_right_shift, ctl.ser_in_left_shift} <= {md, sr, sl};
    {ctl.bus_drive_en1_n, ctl.bus_drive_en2_n} <= {e1, e2};
    drv_en <= md == 2'h3;
    drv_val <= pv;
    repeat (5) @(posedge hclk);
    ctl.clk_in <= 1'b1;
    repeat (4) @(posedge hclk);
    ctl.clk_in <= 1'b0;
    drv_en <= 1'b0;
    repeat (2) @(posedge hclk);
    case (md)
      2'h1: exp_w = {exp_w[6:0], sr};
      2'h2: exp_w = {sl, exp_w[7:1]};
      2'h3: exp_w = pv;
      default: exp_w = exp_w;
    endcase
  endtask : pin_step
  always @(posedge hclk) begin
    if (rd_ph && hreadyout && q.size() > 0) begin
      n = q.pop_front();
      `CHK("hrdata", n[31:0], hrdata & n[63:32])
    end
    rd_ph <= hsel && htrans == HTRANS_NONSEQ && !hwrite && hreadyout;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {hresetn, hsel, hwrite, drv_en, rd_ph, async_clear_n} = 6'b000001;
    ctl = '0;
    {haddr, hwdata, r} = '0;
    htrans = HTRANS_IDLE;
    hsize = HSIZE_WORD;
    {drv_val, exp_w} = '0;
    {error_cnt, checked} = '0;
    r = $urandom(46113);
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    ahb(1'b0, CTRL_ADDR, CTRL_RST, 32'hffff_ffff);
    ahb(1'b1, CTRL_ADDR, 32'h1, 32'h0);
    ahb(1'b1, 32'h8, 32'h5a, 32'h0);
    ahb(1'b0, 32'h8, 32'h0, 32'hffff_ffff);
    $display("test registers done");
    for (int i = 0; i < 40; i++) begin
      r = $urandom;
      pin_step(i < 8 ? i[1:0] : r[1:0], r[2], r[3], r[4] & r[5], r[6] & r[7], r[15:8]);
      ahb(1'b0, STATUS_ADDR, {24'h0, exp_w}, 32'hff);
    end
    ahb(1'b1, STATUS_ADDR, 32'h0, 32'h0);
    ahb(1'b0, STATUS_ADDR, {24'h0, exp_w}, 32'hff);
    $display("test modes done");
    async_clear_n <= 1'b0;
    exp_w = 8'h00;
    ahb(1'b0, STATUS_ADDR, 32'h0, 32'hff);
    async_clear_n <= 1'b1;
    repeat (3) @(posedge hclk);
    pin_step(2'h1, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
    ahb(1'b0, STATUS_ADDR, 32'h1, 32'hff);
    $display("test clear done");
    repeat (2) @(posedge hclk);
    tally_and_finish();
  end
endmodule : usr_core_tb
bind usr_core usr_core_checker usr_core_checker_i (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
  .hresp(hresp), .async_clear_n(async_clear_n), .ctl_pins(ctl_pins), .shared_par_pins_in(shared_par_pins_in),
  .shared_par_pins_drv(shared_par_pins_drv), .ser_out_stage_first(ser_out_stage_first),
  .ser_out_stage_last(ser_out_stage_last));
